//--- verilog/spb_pkg.sv
// Shared constants for the secondary bus control block
package spb_pkg;
  // ----------------------------------------------------------------
  // Configuration space register offsets and bit positions
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_REG_OFFSET = 8'h04;
  localparam logic [7:0] BRIDGE_CTRL_OFFSET = 8'h3e;
  localparam int CMD_PERR_RESP_BIT = 6;
  localparam int BCTL_SERR_FWD_BIT = 1;
  // ----------------------------------------------------------------
  // Bus sizes, timing and reset values
  // ----------------------------------------------------------------
  localparam int AD_WIDTH = 32;
  localparam int CBE_WIDTH = 4;
  localparam int NUM_MASTERS = 10;
  localparam int NUM_REQ = NUM_MASTERS - 1;
  localparam int CLOCK_PERIOD_NS = 100;
  localparam int DEVSEL_TIMEOUT_NS = 500;
  localparam int DEVSEL_TIMEOUT_CYC =
    (DEVSEL_TIMEOUT_NS / CLOCK_PERIOD_NS) < 1 ? 1 :
    DEVSEL_TIMEOUT_NS / CLOCK_PERIOD_NS;
  localparam int PERR_RESP_RESET = 0;
  localparam int SERR_FWD_RESET = 0;
  // ----------------------------------------------------------------
  // Master cycle states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    SPB_IDLE = 4'h1,
    SPB_ADDR = 4'h2,
    SPB_DATA = 4'h4,
    SPB_TURN = 4'h8
  } spb_state_e;
endpackage : spb_pkg

//--- verilog/spb_parity.sv
// Even parity over address/data and command/byte enables
`timescale 1ns/1ns
module spb_parity
  import spb_pkg::*;
(
  // Bus lines
  input wire logic [AD_WIDTH-1:0] ad,
  input wire logic [CBE_WIDTH-1:0] cbe_n,
  // Result
  output logic par
);
  always_comb begin
    par = ^{ad, cbe_n};
  end
endmodule : spb_parity

//--- verilog/spb_ctrl.sv
// Secondary bus control: handshake, parity, arbitration, errors
`timescale 1ns/1ns
module spb_ctrl
  import spb_pkg::*;
#(
  parameter int TIMEOUT_CYC = DEVSEL_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic ARST_N,
  // Configuration straps
  input wire logic PERR_RESP_EN,
  input wire logic SERR_FWD_EN,
  input wire logic ARB_ENABLE,
  // Local master request
  input wire logic MST_START,
  input wire logic MST_WRITE,
  input wire logic MST_LAST,
  input wire logic MST_LOCK,
  input wire logic [AD_WIDTH-1:0] MST_ADDR,
  input wire logic [AD_WIDTH-1:0] MST_WDATA,
  input wire logic [CBE_WIDTH-1:0] MST_CMD,
  input wire logic [CBE_WIDTH-1:0] MST_BE,
  output logic MST_BUSY,
  output logic MST_DONE,
  output logic MST_ABORT,
  output logic MST_STOPPED,
  output logic MST_XFER,
  output logic [AD_WIDTH-1:0] MST_RDATA,
  // Local target read in progress
  input wire logic TGT_READ_ACTIVE,
  // Secondary bus lines
  input wire logic [AD_WIDTH-1:0] S_AD_I,
  output logic [AD_WIDTH-1:0] S_AD_O,
  output logic S_AD_OE,
  input wire logic [CBE_WIDTH-1:0] S_CBE_N_I,
  output logic [CBE_WIDTH-1:0] S_CBE_N_O,
  output logic S_CBE_OE,
  input wire logic S_FRAME_N_I,
  output logic S_FRAME_N_O,
  output logic S_FRAME_OE,
  input wire logic S_IRDY_N_I,
  output logic S_IRDY_N_O,
  output logic S_IRDY_OE,
  input wire logic S_TRDY_N_I,
  input wire logic S_STOP_N_I,
  input wire logic S_DEVSEL_N_I,
  output logic S_LOCK_N_O,
  output logic S_LOCK_OE,
  input wire logic SEC_PARITY_BIT_I,
  output logic SEC_PARITY_BIT_O,
  output logic SEC_PARITY_BIT_OE,
  output logic SEC_PARITY_ERROR_LINE_O,
  output logic SEC_PARITY_ERROR_LINE_OE,
  input wire logic SEC_SYSTEM_ERROR_IN_N,
  // Arbitration
  input wire logic SEC_REQUEST_IN_ZERO_N,
  input wire logic [NUM_REQ-1:1] S_REQ_N,
  output logic SEC_GRANT_OUT_ZERO_N,
  output logic [NUM_REQ-1:1] S_GNT_N,
  // Primary side
  output logic P_SERR_N
);
  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_s1, rst_n;
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // ----------------------------------------------------------------
  // Parity
  // ----------------------------------------------------------------
  logic par_calc_out, par_calc_in;
  // Received parity covers the lines captured one edge earlier
  logic [AD_WIDTH-1:0] ad_q;
  logic [CBE_WIDTH-1:0] cbe_q;
  spb_parity u_par_out (.ad(S_AD_O), .cbe_n(S_CBE_N_O), .par(par_calc_out));
  spb_parity u_par_in (.ad(ad_q), .cbe_n(cbe_q), .par(par_calc_in));

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  logic [NUM_REQ-1:0] reqs, gnt, next_gnt;
  logic bus_idle, own_grant, own_req;
  logic [NUM_REQ-1:0] gnt_n_reg, next_gnt_n_reg;
  assign reqs = {~S_REQ_N, ~SEC_REQUEST_IN_ZERO_N};
  assign bus_idle = S_FRAME_N_I & S_IRDY_N_I;

  // Priority pick among requests; the bridge is master index nine
  function automatic logic [NUM_REQ-1:0] pick(input logic [NUM_REQ-1:0] r);
    logic [NUM_REQ-1:0] g;
    g = '0;
    for (int i = NUM_REQ - 1; i >= 0; i--) begin
      if (r[i]) g = NUM_REQ'(1) << i;
    end
    return g;
  endfunction : pick

  spb_state_e state, next_state;
  logic bridge_gnt, next_bridge_gnt;
  always_comb begin
    next_gnt = gnt;
    next_bridge_gnt = bridge_gnt;
    if (!ARB_ENABLE) begin
      next_gnt = '0;
      next_bridge_gnt = 1'b0;
    end else if (bus_idle && state == SPB_IDLE) begin
      // Bridge takes priority so posted traffic cannot starve
      next_bridge_gnt = own_req;
      next_gnt = own_req ? '0 : pick(reqs);
    end
    next_gnt_n_reg = ~next_gnt;
    // Grant zero pin turns into our request toward an outside arbiter
    if (!ARB_ENABLE) next_gnt_n_reg[0] = ~own_req;
  end
  assign own_req = MST_START | (state != SPB_IDLE);
  // Request zero pin turns into our grant when arbiter is off
  assign own_grant = ARB_ENABLE ? bridge_gnt :
                     ~SEC_REQUEST_IN_ZERO_N;
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      gnt <= '0;
      bridge_gnt <= 1'b0;
      gnt_n_reg <= '1;
    end else begin
      gnt <= next_gnt;
      bridge_gnt <= next_bridge_gnt;
      gnt_n_reg <= next_gnt_n_reg;
    end
  end
  assign SEC_GRANT_OUT_ZERO_N = gnt_n_reg[0];
  assign S_GNT_N = gnt_n_reg[NUM_REQ-1:1];

  // ----------------------------------------------------------------
  // Master cycle
  // ----------------------------------------------------------------
  logic [7:0] tmo, next_tmo;
  logic claimed, next_claimed, last, next_last, wr, next_wr;
  logic frame_o, next_frame_o, irdy_o, next_irdy_o, lock_o, next_lock_o;
  logic oe, next_oe, done, next_done, abrt, next_abrt, stp, next_stp;
  logic xfer, next_xfer;
  logic [AD_WIDTH-1:0] ad_o, next_ad_o, rdata, next_rdata;
  logic [CBE_WIDTH-1:0] cbe_o, next_cbe_o;
  logic data_done;
  assign data_done = ~S_IRDY_N_I & ~S_TRDY_N_I;

  always_comb begin
    next_state = state;
    next_tmo = tmo;
    next_claimed = claimed;
    next_last = last;
    next_wr = wr;
    next_frame_o = frame_o;
    next_irdy_o = irdy_o;
    next_lock_o = lock_o;
    next_oe = oe;
    next_ad_o = ad_o;
    next_cbe_o = cbe_o;
    next_rdata = rdata;
    next_done = 1'b0;
    next_abrt = 1'b0;
    next_stp = 1'b0;
    next_xfer = 1'b0;
    unique case (state)
      SPB_IDLE: begin
        if (MST_START && own_grant && bus_idle) begin
          next_state = SPB_ADDR;
          next_frame_o = 1'b0;
          next_oe = 1'b1;
          next_ad_o = MST_ADDR;
          next_cbe_o = MST_CMD;
          next_wr = MST_WRITE;
          next_last = MST_LAST;
          next_lock_o = ~MST_LOCK;
          next_claimed = 1'b0;
          next_tmo = '0;
        end
      end
      SPB_ADDR: begin
        next_state = SPB_DATA;
        next_irdy_o = 1'b0;
        next_ad_o = MST_WDATA;
        next_cbe_o = MST_BE;
        if (last) next_frame_o = 1'b1;
      end
      SPB_DATA: begin
        if (!S_DEVSEL_N_I) next_claimed = 1'b1;
        if (!claimed && S_DEVSEL_N_I) next_tmo = tmo + 8'h01;
        if (!claimed && S_DEVSEL_N_I && tmo >= 8'(TIMEOUT_CYC)) begin
          next_abrt = 1'b1;
          next_state = SPB_TURN;
        end else if (!S_STOP_N_I && !S_DEVSEL_N_I) begin
          next_stp = 1'b1;
          next_xfer = data_done;
          // A disconnect with data still completes that data phase
          if (data_done) next_rdata = S_AD_I;
          next_state = SPB_TURN;
        end else if (data_done) begin
          next_xfer = 1'b1;
          next_rdata = S_AD_I;
          if (frame_o) begin
            next_done = 1'b1;
            next_state = SPB_TURN;
          end else begin
            next_ad_o = MST_WDATA;
            next_cbe_o = MST_BE;
            next_last = MST_LAST;
            if (MST_LAST) next_frame_o = 1'b1;
          end
        end
        if (next_state == SPB_TURN) next_frame_o = 1'b1;
      end
      SPB_TURN: begin
        next_state = SPB_IDLE;
        next_irdy_o = 1'b1;
        next_frame_o = 1'b1;
        next_lock_o = 1'b1;
        next_oe = 1'b0;
      end
    endcase
  end
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      state <= SPB_IDLE;
      tmo <= '0;
      claimed <= 1'b0;
      last <= 1'b0;
      wr <= 1'b0;
      frame_o <= 1'b1;
      irdy_o <= 1'b1;
      lock_o <= 1'b1;
      oe <= 1'b0;
      ad_o <= '0;
      cbe_o <= '1;
      rdata <= '0;
      done <= 1'b0;
      abrt <= 1'b0;
      stp <= 1'b0;
      xfer <= 1'b0;
    end else begin
      state <= next_state;
      tmo <= next_tmo;
      claimed <= next_claimed;
      last <= next_last;
      wr <= next_wr;
      frame_o <= next_frame_o;
      irdy_o <= next_irdy_o;
      lock_o <= next_lock_o;
      oe <= next_oe;
      ad_o <= next_ad_o;
      cbe_o <= next_cbe_o;
      rdata <= next_rdata;
      done <= next_done;
      abrt <= next_abrt;
      stp <= next_stp;
      xfer <= next_xfer;
    end
  end

  // ----------------------------------------------------------------
  // Parity drive, check and error forwarding
  // ----------------------------------------------------------------
  logic par_o, next_par_o, par_oe, next_par_oe;
  logic chk, next_chk, perr_o, next_perr_o, serr, next_serr;
  logic ad_oe, next_ad_oe;
  always_comb begin
    // Address phase or write data: drive parity one clock later
    next_ad_oe = next_oe && (next_state == SPB_ADDR || next_wr);
    next_par_o = par_calc_out;
    next_par_oe = ad_oe;
    // Parity for a transfer at edge n arrives at edge n+1
    next_chk = TGT_READ_ACTIVE & data_done;
    next_perr_o = chk && PERR_RESP_EN &&
                  (par_calc_in != SEC_PARITY_BIT_I);
    next_serr = ~(SERR_FWD_EN & ~SEC_SYSTEM_ERROR_IN_N);
  end
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      par_o <= 1'b0;
      par_oe <= 1'b0;
      chk <= 1'b0;
      perr_o <= 1'b0;
      serr <= 1'b1;
      ad_oe <= 1'b0;
      ad_q <= '0;
      cbe_q <= '0;
    end else begin
      par_o <= next_par_o;
      par_oe <= next_par_oe;
      chk <= next_chk;
      perr_o <= next_perr_o;
      serr <= next_serr;
      ad_oe <= next_ad_oe;
      ad_q <= S_AD_I;
      cbe_q <= S_CBE_N_I;
    end
  end
  // ----------------------------------------------------------------
  // Output pins
  // ----------------------------------------------------------------
  assign S_AD_O = ad_o;
  assign S_AD_OE = ad_oe;
  assign S_CBE_N_O = cbe_o;
  assign S_CBE_OE = oe;
  assign S_FRAME_N_O = frame_o;
  assign S_FRAME_OE = oe;
  assign S_IRDY_N_O = irdy_o;
  assign S_IRDY_OE = oe;
  assign S_LOCK_N_O = lock_o;
  assign S_LOCK_OE = oe & ~lock_o;
  assign SEC_PARITY_BIT_O = par_o;
  assign SEC_PARITY_BIT_OE = par_oe;
  // Open-drain style: only ever pulled low while a mismatch is flagged
  assign SEC_PARITY_ERROR_LINE_O = 1'b0;
  assign SEC_PARITY_ERROR_LINE_OE = perr_o;
  assign P_SERR_N = serr;
  assign MST_BUSY = oe;
  assign MST_DONE = done;
  assign MST_ABORT = abrt;
  assign MST_STOPPED = stp;
  assign MST_XFER = xfer;
  assign MST_RDATA = rdata;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_xfer_needs_handshake;
    @(posedge CLOCK) disable iff (!rst_n)
    xfer |-> $past(data_done);
  endproperty
  a_xfer_needs_handshake: assert property (p_xfer_needs_handshake)
    else $error("transfer without IRDY and TRDY");
  property p_par_delay;
    @(posedge CLOCK) disable iff (!rst_n)
    ad_oe |=> (SEC_PARITY_BIT_OE && SEC_PARITY_BIT_O == ^{$past(S_AD_O),
      $past(S_CBE_N_O)});
  endproperty
  a_par_delay: assert property (p_par_delay)
    else $error("parity not driven one clock after data");
  property p_perr_gated;
    @(posedge CLOCK) disable iff (!rst_n)
    SEC_PARITY_ERROR_LINE_OE |-> $past(PERR_RESP_EN) && $past(chk);
  endproperty
  a_perr_gated: assert property (p_perr_gated)
    else $error("parity error driven while disabled");
  property p_serr_fwd;
    @(posedge CLOCK) disable iff (!rst_n)
    !P_SERR_N |-> $past(SERR_FWD_EN) && !$past(SEC_SYSTEM_ERROR_IN_N);
  endproperty
  a_serr_fwd: assert property (p_serr_fwd)
    else $error("system error forwarded while disabled");
  property p_abort_timeout;
    @(posedge CLOCK) disable iff (!rst_n)
    MST_ABORT |-> $past(S_DEVSEL_N_I) && !$past(claimed);
  endproperty
  a_abort_timeout: assert property (p_abort_timeout)
    else $error("master abort although claimed");
  property p_stop_ends;
    @(posedge CLOCK) disable iff (!rst_n)
    MST_STOPPED |-> S_FRAME_N_O ##1 !MST_BUSY;
  endproperty
  a_stop_ends: assert property (p_stop_ends)
    else $error("master kept going after STOP");
  property p_req_out;
    @(posedge CLOCK) disable iff (!rst_n)
    (!ARB_ENABLE && MST_START && state == SPB_IDLE) |=>
      !SEC_GRANT_OUT_ZERO_N;
  endproperty
  a_req_out: assert property (p_req_out)
    else $error("grant zero did not request");
  property p_one_grant;
    @(posedge CLOCK) disable iff (!rst_n)
    $countones(~S_GNT_N) + 32'(bridge_gnt) <= 1;
  endproperty
  a_one_grant: assert property (p_one_grant)
    else $error("more than one grant");
endmodule : spb_ctrl

//--- tb/spb_tgt_model.sv
// Behavioural secondary bus target used as the far side in the bench
`timescale 1ns/1ns
module spb_tgt_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Lines seen from the target
  input wire logic frame_n,
  input wire logic irdy_n,
  input wire logic [3:0] cbe_n,
  // Behaviour knobs
  input wire logic respond,
  input wire logic stop_en,
  input wire logic [1:0] waits,
  input wire logic [31:0] rdata,
  // Driven lines
  output logic trdy_n,
  output logic stop_n,
  output logic devsel_n,
  output logic [31:0] ad,
  output logic ad_oe,
  output logic par,
  output logic par_oe
);
  logic act;
  logic rd;
  logic fr_q;
  logic [1:0] cnt;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {act, rd, ad_oe, par_oe, par} <= '0;
      {trdy_n, stop_n, devsel_n, fr_q} <= '1;
      cnt <= '0;
      ad <= '0;
    end else begin
      fr_q <= frame_n;
      // Read parity follows its data by one clock
      par_oe <= ad_oe;
      par <= ^{ad, cbe_n};
      if (!act) begin
        if (!frame_n && fr_q && respond) begin
          act <= 1'b1;
          rd <= !cbe_n[0];
          cnt <= waits;
          devsel_n <= 1'b0;
        end
      end else if (!trdy_n && !irdy_n) begin
        trdy_n <= 1'b1;
        ad_oe <= 1'b0;
        cnt <= waits;
        if (frame_n) begin
          act <= 1'b0;
          devsel_n <= 1'b1;
          stop_n <= 1'b1;
        end
      end else if (!stop_n) begin
        if (frame_n && irdy_n) begin
          act <= 1'b0;
          devsel_n <= 1'b1;
          stop_n <= 1'b1;
        end
      end else if (cnt == 2'h0) begin
        trdy_n <= 1'b0;
        stop_n <= !stop_en;
        ad <= rdata;
        ad_oe <= rd;
      end else begin
        cnt <= cnt - 2'h1;
      end
    end
  end
endmodule : spb_tgt_model

//--- tb/secondary_pci_bus_control_tb.sv
// Self-checking bench for the secondary bus control block
`timescale 1ns/1ns
module secondary_pci_bus_control_tb;
  import spb_pkg::*;
  logic CLOCK = 1'b0;
  logic ARST_N = 1'b0;
  logic PERR_RESP_EN = 1'b0, SERR_FWD_EN = 1'b0, ARB_ENABLE = 1'b1;
  logic MST_START = 1'b0, MST_WRITE = 1'b0, MST_LAST = 1'b1;
  logic MST_LOCK = 1'b0, TGT_READ_ACTIVE = 1'b0;
  logic [AD_WIDTH-1:0] MST_ADDR = 32'h0000_1000;
  logic [AD_WIDTH-1:0] MST_WDATA = 32'h1234_abcd;
  logic [CBE_WIDTH-1:0] MST_CMD = 4'h7, MST_BE = 4'h0;
  logic SEC_SYSTEM_ERROR_IN_N = 1'b1, SEC_REQUEST_IN_ZERO_N = 1'b1;
  logic [NUM_REQ-1:1] S_REQ_N = '1;
  logic MST_BUSY, MST_DONE, MST_ABORT, MST_STOPPED, MST_XFER;
  logic [AD_WIDTH-1:0] MST_RDATA, S_AD_O;
  logic [CBE_WIDTH-1:0] S_CBE_N_O;
  logic S_AD_OE, S_CBE_OE, S_FRAME_N_O, S_FRAME_OE, S_IRDY_N_O, S_IRDY_OE;
  logic S_LOCK_N_O, S_LOCK_OE, SEC_PARITY_BIT_O, SEC_PARITY_BIT_OE;
  logic SEC_PARITY_ERROR_LINE_O, SEC_PARITY_ERROR_LINE_OE;
  logic SEC_GRANT_OUT_ZERO_N, P_SERR_N;
  logic [NUM_REQ-1:1] S_GNT_N;
  // Undriven AD and parity lines wander so a stale value never passes
  logic [31:0] x_ad = 32'h0;
  logic [3:0] x_cbe_n = 4'hf;
  logic x_irdy_n = 1'b1, x_trdy_n = 1'b1, x_par = 1'b0, x_hold = 1'b0;
  logic t_trdy_n, t_stop_n, t_devsel_n, t_ad_oe, t_par, t_par_oe;
  logic respond = 1'b1, stop_en = 1'b0;
  logic [1:0] waits = 2'h1;
  logic [31:0] t_ad, rdata = 32'h5a5a_c3c3;
  wire logic [31:0] ad_w = S_AD_OE ? S_AD_O : t_ad_oe ? t_ad : x_ad;
  wire logic [3:0] cbe_w = S_CBE_OE ? S_CBE_N_O : x_cbe_n;
  wire logic frame_w = S_FRAME_OE ? S_FRAME_N_O : 1'b1;
  wire logic irdy_w = S_IRDY_OE ? S_IRDY_N_O : x_irdy_n;
  wire logic trdy_w = t_trdy_n & x_trdy_n;
  wire logic par_w = SEC_PARITY_BIT_OE ? SEC_PARITY_BIT_O :
    t_par_oe ? t_par : x_par;
  int fail_count = 0, n_checks = 0;
  int n_x, endk, lk_seen, greq, early;
  logic [31:0] got_d, pa;
  logic [3:0] pc;
  logic pv = 1'b0;

  spb_ctrl #(.TIMEOUT_CYC(2)) i_spb_ctrl (.*, .S_AD_I(ad_w),
    .S_CBE_N_I(cbe_w), .S_FRAME_N_I(frame_w), .S_IRDY_N_I(irdy_w),
    .S_TRDY_N_I(trdy_w), .S_STOP_N_I(t_stop_n),
    .S_DEVSEL_N_I(t_devsel_n), .SEC_PARITY_BIT_I(par_w));
  spb_tgt_model i_spb_tgt_model (.clk(CLOCK), .rst_n(ARST_N),
    .frame_n(frame_w), .irdy_n(irdy_w), .cbe_n(cbe_w), .respond(respond),
    .stop_en(stop_en), .waits(waits), .rdata(rdata), .trdy_n(t_trdy_n),
    .stop_n(t_stop_n), .devsel_n(t_devsel_n), .ad(t_ad), .ad_oe(t_ad_oe),
    .par(t_par), .par_oe(t_par_oe));

  always #50 CLOCK = ~CLOCK;
  always @(posedge CLOCK) begin
    if (!x_hold) begin
      x_ad <= ~x_ad;
      x_par <= ~x_par;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic test_done;
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done

  // Parity driven by the bridge must match the previous cycle's lines
  always @(negedge CLOCK) begin
    if (pv && SEC_PARITY_BIT_OE)
      chk(32'(SEC_PARITY_BIT_O), 32'(^{pa, pc}));
    pa = ad_w;
    pc = cbe_w;
    pv = S_AD_OE;
  end

  task automatic do_mst(input logic w, input logic l, input logic lk);
    int i;
    {n_x, endk, lk_seen, greq, early} = '0;
    @(posedge CLOCK);
    MST_START <= 1'b1;
    MST_WRITE <= w;
    MST_LAST <= l;
    MST_LOCK <= lk;
    MST_CMD <= w ? 4'h7 : 4'h6;
    for (i = 0; i < 80 && endk == 0; i++) begin
      @(posedge CLOCK);
      if (MST_BUSY === 1'b1) MST_START <= 1'b0;
      if (MST_XFER === 1'b1) n_x++;
      if (S_LOCK_OE === 1'b1 && S_LOCK_N_O === 1'b0) lk_seen = 1;
      if (!irdy_w && !trdy_w && S_AD_OE) got_d = S_AD_O;
      if (!ARB_ENABLE && SEC_REQUEST_IN_ZERO_N && !frame_w) early = 1;
      if (!ARB_ENABLE && SEC_GRANT_OUT_ZERO_N === 1'b0) begin
        SEC_REQUEST_IN_ZERO_N <= 1'b0;
        greq = 1;
      end
      if (MST_DONE === 1'b1) endk = 1;
      else if (MST_ABORT === 1'b1) endk = 2;
      else if (MST_STOPPED === 1'b1) endk = 3;
    end
    SEC_REQUEST_IN_ZERO_N <= 1'b1;
    repeat (3) @(posedge CLOCK);
  endtask : do_mst

  task automatic t_reset;
    chk({S_GNT_N, SEC_GRANT_OUT_ZERO_N, P_SERR_N}, 32'h3ff);
    chk({S_AD_OE, S_FRAME_OE, S_IRDY_OE, SEC_PARITY_BIT_OE, S_LOCK_OE,
      SEC_PARITY_ERROR_LINE_OE}, 32'h0);
  endtask : t_reset

  task automatic t_write;
    waits <= 2'h2;
    do_mst(1'b1, 1'b1, 1'b1);
    chk(endk, 1);
    chk(n_x, 1);
    chk(got_d, MST_WDATA);
    chk(lk_seen, 1);
  endtask : t_write

  task automatic t_read;
    waits <= 2'h0;
    do_mst(1'b0, 1'b1, 1'b0);
    chk(endk, 1);
    chk(MST_RDATA, rdata);
  endtask : t_read

  task automatic t_stop;
    stop_en <= 1'b1;
    rdata <= 32'h0bad_f00d;
    do_mst(1'b0, 1'b0, 1'b0);
    chk(endk, 3);
    chk(n_x, 1);
    chk(MST_RDATA, 32'h0bad_f00d);
    stop_en <= 1'b0;
  endtask : t_stop

  task automatic t_abort;
    respond <= 1'b0;
    do_mst(1'b1, 1'b1, 1'b0);
    chk(endk, 2);
    chk(n_x, 0);
    respond <= 1'b1;
  endtask : t_abort

  task automatic t_extarb;
    ARB_ENABLE <= 1'b0;
    do_mst(1'b1, 1'b1, 1'b0);
    chk(greq, 1);
    chk(early, 0);
    chk(endk, 1);
    ARB_ENABLE <= 1'b1;
  endtask : t_extarb

  task automatic t_arb;
    int i;
    int ok;
    for (i = 1; i < NUM_REQ; i++) begin
      S_REQ_N[i] <= 1'b0;
      ok = 0;
      repeat (10) begin
        @(posedge CLOCK);
        if (S_GNT_N[i] === 1'b0) ok = 1;
      end
      chk(ok, 1);
      S_REQ_N <= '1;
      repeat (3) @(posedge CLOCK);
    end
    // Lowest index wins among outside masters
    SEC_REQUEST_IN_ZERO_N <= 1'b0;
    S_REQ_N[2] <= 1'b0;
    repeat (8) @(posedge CLOCK);
    chk({S_GNT_N[2], SEC_GRANT_OUT_ZERO_N}, 32'h2);
    SEC_REQUEST_IN_ZERO_N <= 1'b1;
    S_REQ_N <= '1;
    repeat (3) @(posedge CLOCK);
  endtask : t_arb

  task automatic t_perr;
    int k;
    for (k = 0; k < 4; k++) begin
      // Stop the wander one edge before the lines are driven here
      @(posedge CLOCK);
      x_hold <= 1'b1;
      @(posedge CLOCK);
      x_ad <= 32'h0f0f_0001;
      x_cbe_n <= 4'h0;
      x_irdy_n <= 1'b0;
      x_trdy_n <= 1'b0;
      TGT_READ_ACTIVE <= 1'b1;
      PERR_RESP_EN <= k[0];
      @(posedge CLOCK);
      x_irdy_n <= 1'b1;
      x_trdy_n <= 1'b1;
      TGT_READ_ACTIVE <= 1'b0;
      x_par <= 1'b1 ^ k[1];
      @(posedge CLOCK);
      x_hold <= 1'b0;
      #1 chk(32'(SEC_PARITY_ERROR_LINE_OE), 32'(k[0] & k[1]));
    end
  endtask : t_perr

  task automatic t_serr;
    int k;
    for (k = 0; k < 2; k++) begin
      @(posedge CLOCK);
      SERR_FWD_EN <= k[0];
      SEC_SYSTEM_ERROR_IN_N <= 1'b0;
      repeat (4) @(posedge CLOCK);
      #1 chk(32'(P_SERR_N), 32'(!k[0]));
      @(posedge CLOCK);
      SEC_SYSTEM_ERROR_IN_N <= 1'b1;
      repeat (4) @(posedge CLOCK);
      #1 chk(32'(P_SERR_N), 32'h1);
    end
  endtask : t_serr

  initial begin
    repeat (6) @(posedge CLOCK);
    ARST_N <= 1'b1;
    repeat (4) @(posedge CLOCK);
    t_reset();
    t_write();
    t_read();
    t_stop();
    t_abort();
    t_extarb();
    t_arb();
    t_perr();
    t_serr();
    test_done();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #(100 * 5000);
    fail_count++;
    test_done();
  end
endmodule : secondary_pci_bus_control_tb
